// *** dv/ascii_system_command_parser_checker.sv ***
// Port-timing checker of the parser top.
// Assumes it is bound onto the parser top and sees only its ports.
`timescale 1ns/1ps
module ascii_system_command_parser_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [15:0] aux_flags
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Character taken on the receive side, and the closing return of a reply.
  sequence rx_take_s;
    rx_valid && rx_ready;
  endsequence
  sequence tx_end_s;
    tx_valid && tx_ready && tx_data == cmd_parser_pkg::CH_CR;
  endsequence
  logic hit;
  assign hit = reg_addr == cmd_parser_pkg::FLAG_REG_ADDR;
  a_no_early_decode: assert property (rx_take_s ##0 rx_data != cmd_parser_pkg::CH_CR |=> rx_ready)
    else $error("collection stopped before the return");
  a_cr_starts_decode: assert property (rx_take_s ##0 rx_data == cmd_parser_pkg::CH_CR |=> !rx_ready && !tx_valid)
    else $error("return did not start decoding");
  a_reply_ends_cr: assert property (tx_end_s |=> !tx_valid ##1 rx_ready)
    else $error("reply did not end at its return");
  a_lead_marks: assert property ($rose(tx_valid) |-> tx_data inside {8'h21, 8'h3e, 8'h3f})
    else $error("reply lead character wrong");
  a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply character changed while stalled");
  a_no_rx_reply: assert property (tx_valid |-> !rx_ready)
    else $error("receiving during a reply");
  a_rd_returns: assert property (reg_rd && hit |=> reg_rvalid && reg_rdata == $past(aux_flags))
    else $error("flag register read wrong");
  a_unmapped_zero: assert property (reg_rd && !hit |=> reg_rvalid && reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");
  a_reg_write: assert property (reg_wr && hit && rx_ready |=> aux_flags == $past(reg_wdata))
    else $error("register write not applied");
  a_flags_quiet: assert property (rx_ready && !(reg_wr && hit) |=> $stable(aux_flags))
    else $error("flags changed without a write");
endmodule
bind ascii_system_command_parser ascii_system_command_parser_checker u_chk (
  .clock(clock), .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .aux_flags(aux_flags));

// *** dv/host_model.sv ***
// Host model: sends command frames and collects reply characters.
// Assumes the parser takes a character at an edge where rx_ready is high.
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic slow
);
  logic [7:0] rq[$];
  bit hang = 0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // Collects reply characters; a slow host stalls every other cycle.
  always @(posedge clock) begin
    if (tx_valid && tx_ready) begin
      rq.push_back(tx_data);
    end
    tx_ready <= !slow || !tx_ready;
  end
  // Sends a frame plus its return, holding each character until taken.
  task automatic send(input string s);
    int n;
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge clock);
      #1;
      rx_valid = 1'b1;
      rx_data = (i == s.len()) ? 8'h0d : s[i];
      n = 0;
      @(negedge clock);
      while (!rx_ready && n < 300) begin
        @(negedge clock);
        n++;
      end
      hang |= n == 300;
    end
    @(posedge clock);
    #1;
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
endmodule

// *** dv/tb_ascii_system_command_parser.sv ***
// Testbench of the parser against a bench model of the flags.
// Assumes the host model drives the character stream.
`timescale 1ns/1ps
module tb_ascii_system_command_parser;
  logic clock, rst_n, rx_valid, rx_ready, tx_valid, tx_ready, reg_wr, reg_rd, reg_rvalid, slow;
  logic [7:0] rx_data, tx_data;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, aux_flags;
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h1501_2207;
  logic [15:0] fm = 16'h0000;
  ascii_system_command_parser #(.MODEL_NUM(8'h3c)) u_ascii_system_command_parser (
    .clock(clock), .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .aux_flags(aux_flags));
  host_model u_host_model (.clock(clock), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));
  // Free-running 125 MHz clock.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Upper-case hex text of the low n digits.
  function automatic string hx(input logic [15:0] v, input int n);
    string s = "";
    for (int i = n - 1; i >= 0; i--) s = {s, $sformatf("%h", v[4*i+:4])};
    return s.toupper();
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Sends a frame and compares the reply; an empty text means silence.
  task automatic txn(input string cmd, input string exp);
    int n;
    int lim;
    n = 0;
    lim = (exp == "") ? 40 : 400;
    u_host_model.rq.delete();
    u_host_model.send(cmd);
    while (u_host_model.rq.size() < exp.len() + 1 && n < lim) begin
      @(negedge clock);
      n++;
    end
    if (u_host_model.hang || (n == lim && exp != "")) begin
      bad_count++;
      wrap_up();
    end
    chk({cmd, " length"}, 16'(exp.len() + (exp != "")), 16'(u_host_model.rq.size()));
    for (int i = 0; i < u_host_model.rq.size() && exp != ""; i++)
      chk(cmd, (i == exp.len()) ? 16'h000d : {8'h00, exp[i]}, {8'h00, u_host_model.rq[i]});
  endtask
  // One register access; a read compares data with d.
  task automatic reg_acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    if (!wr) chk("register read", d, reg_rdata);
    if (!wr) chk("read valid", 16'h0001, {15'h0000, reg_rvalid});
  endtask
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, slow} = 3'b000;
    {reg_addr, reg_wdata} = 32'h0000_0000;
    repeat (3) @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk("flags at reset", 16'h0000, aux_flags);
    txn("$01M", "!01603C");
    txn("$01F", $sformatf("!01%s", cmd_parser_pkg::FW_REV_TEXT));
    txn("$01Q", "?01");
    txn("$02M", "");
    txn("$0GM", "");
    txn("#01Vd00000123456789ABC", "");
    slow = 1'b1;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      fm = seed[15:0];
      txn({"#01Vd00000000", hx(fm, 4)}, ">01");
      txn(k[0] ? "$01Vd" : "#01Vd", {">010000", hx(fm, 4)});
    end
    for (int k = 0; k < 16; k += 5) begin
      seed = lfsr(seed);
      fm[k] = seed[0];
      txn({"#01Vd100", hx(k, 1), "000000", hx(seed[0], 1)}, ">01");
    end
    txn("$01M#01Vd", {">010000", hx(fm, 4)});
    txn("#01Vd20000000001", "?01");
    seed = lfsr(seed);
    fm = seed[31:16];
    reg_acc(1'b1, cmd_parser_pkg::FLAG_REG_ADDR, fm);
    txn("$01Vd", {">010000", hx(fm, 4)});
    txn("#01Vd00000000A5C3", ">01");
    reg_acc(1'b0, cmd_parser_pkg::FLAG_REG_ADDR, 16'ha5c3);
    reg_acc(1'b0, 16'h9d73, 16'h0000);
    reg_acc(1'b1, 16'h9d73, 16'hffff);
    chk("flags after unmapped write", 16'ha5c3, aux_flags);
    wrap_up();
  end
endmodule

// *** hdl/ascii_system_command_parser.sv ***
// Top of the ASCII system command parser with its auxiliary flag register.
// Assumes rx characters and register strobes are synchronous to clock.
`timescale 1ns/1ps
module ascii_system_command_parser #(
  parameter logic [7:0] MODEL_NUM = 8'h00 // Arbitrary model number.
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic [15:0] aux_flags
);

  typedef enum {ST_HUNT, ST_BODY, ST_EXEC, ST_WAIT} state_t;

  state_t state_r;
  logic [7:0] mem_r [cmd_parser_pkg::BODY_MAX];
  logic [4:0] len_r;
  logic [7:0] delim_r;
  logic ovf_r;
  logic [15:0] flags_r;
  logic [15:0] rdata_r;
  logic rvalid_r;

  logic syn_ok, addr_ok, is_flag_op, all_hex, sel_all, sel_one;
  logic cmd_id, cmd_fw, cmd_rd, cmd_wr, reply;
  logic [31:0] acc;
  logic [3:0] flag_num;
  cmd_parser_pkg::resp_buf_t rbuf;
  cmd_parser_pkg::resp_len_t rlen;
  logic is_delim, take;

  resp_if rsp ();

  assign is_delim = (rx_data == cmd_parser_pkg::CH_DOLLAR) || (rx_data == cmd_parser_pkg::CH_HASH);
  assign rx_ready = (state_r == ST_HUNT) || (state_r == ST_BODY);
  assign take = rx_valid && rx_ready;

  // Frame collector and sequencer.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_HUNT;
      len_r <= '0;
      delim_r <= 8'h00;
      ovf_r <= 1'b0;
    end else begin
      case (state_r)
        ST_HUNT, ST_BODY: begin
          if (take && is_delim) begin
            state_r <= ST_BODY; // RULE16
            delim_r <= rx_data;
            len_r <= '0;
            ovf_r <= 1'b0;
          end else if (take && state_r == ST_BODY) begin
            if (rx_data == cmd_parser_pkg::CH_CR) begin
              state_r <= ST_EXEC; // RULE3
            end else if (len_r == 5'(cmd_parser_pkg::BODY_MAX)) begin
              ovf_r <= 1'b1;
            end else begin
              len_r <= len_r + 5'd1;
            end
          end
        end
        ST_EXEC: begin
          state_r <= reply ? ST_WAIT : ST_HUNT;
        end
        ST_WAIT: begin
          if (!rsp.busy) begin
            state_r <= ST_HUNT;
          end
        end
        default: begin
          state_r <= ST_HUNT;
        end
      endcase
    end
  end

  // Body character store; written only while collecting.
  always_ff @(posedge clock) begin
    if (take && state_r == ST_BODY && !is_delim && rx_data != cmd_parser_pkg::CH_CR &&
        len_r < 5'(cmd_parser_pkg::BODY_MAX)) begin
      mem_r[len_r[3:0]] <= rx_data; // RULE16
    end
  end

  // Decode of the collected frame.
  always_comb begin
    acc = '0;
    all_hex = 1'b1;
    syn_ok = !ovf_r && len_r >= 5'd2 && cmd_parser_pkg::is_hex(mem_r[0]) &&
             cmd_parser_pkg::is_hex(mem_r[1]); // RULE2
    addr_ok = {cmd_parser_pkg::hex_val(mem_r[0]), cmd_parser_pkg::hex_val(mem_r[1])} ==
              cmd_parser_pkg::NODE_ADDR; // RULE2
    is_flag_op = mem_r[2] == cmd_parser_pkg::CH_V && mem_r[3] == cmd_parser_pkg::CH_LD;
    for (int i = cmd_parser_pkg::POS_SEL; i < cmd_parser_pkg::BODY_MAX; i++) begin
      if (i < int'(len_r) && !cmd_parser_pkg::is_hex(mem_r[i])) begin
        all_hex = 1'b0;
      end
    end
    for (int i = cmd_parser_pkg::POS_DATA; i < cmd_parser_pkg::BODY_MAX; i++) begin
      if (i < int'(len_r)) begin
        acc = {acc[27:0], cmd_parser_pkg::hex_val(mem_r[i])}; // RULE13
      end
    end
    sel_all = mem_r[4] == cmd_parser_pkg::CH_ZERO && mem_r[5] == cmd_parser_pkg::CH_ZERO &&
              mem_r[6] == cmd_parser_pkg::CH_ZERO && mem_r[7] == cmd_parser_pkg::CH_ZERO; // RULE12
    sel_one = mem_r[4] == cmd_parser_pkg::CH_ONE && cmd_parser_pkg::hex_val(mem_r[5]) == 4'h0 &&
              cmd_parser_pkg::hex_val(mem_r[6]) == 4'h0; // RULE12
    flag_num = cmd_parser_pkg::hex_val(mem_r[7]);
    cmd_id = delim_r == cmd_parser_pkg::CH_DOLLAR && len_r == 5'(cmd_parser_pkg::LEN_SHORT) &&
             mem_r[2] == cmd_parser_pkg::CH_M; // RULE1
    cmd_fw = delim_r == cmd_parser_pkg::CH_DOLLAR && len_r == 5'(cmd_parser_pkg::LEN_SHORT) &&
             mem_r[2] == cmd_parser_pkg::CH_F; // RULE7
    cmd_rd = len_r == 5'(cmd_parser_pkg::LEN_FLAG_RD) && is_flag_op;
    cmd_wr = delim_r == cmd_parser_pkg::CH_HASH && is_flag_op && all_hex && (sel_all || sel_one) &&
             len_r >= 5'(cmd_parser_pkg::LEN_WR_MIN) &&
             len_r <= 5'(cmd_parser_pkg::LEN_WR_MAX); // RULE10
    reply = syn_ok && addr_ok; // RULE6
  end

  // Reply assembly: marker, own address, then the payload of the command.
  always_comb begin
    rbuf = '0;
    rbuf[1] = cmd_parser_pkg::hex_char(cmd_parser_pkg::NODE_ADDR[7:4]);
    rbuf[2] = cmd_parser_pkg::hex_char(cmd_parser_pkg::NODE_ADDR[3:0]);
    rlen = 5'd3;
    if (cmd_id) begin
      rbuf[0] = cmd_parser_pkg::CH_BANG; // RULE9
      rbuf[3] = cmd_parser_pkg::MODEL_PREFIX[15:8]; // RULE4
      rbuf[4] = cmd_parser_pkg::MODEL_PREFIX[7:0];
      rbuf[5] = cmd_parser_pkg::hex_char(MODEL_NUM[7:4]);
      rbuf[6] = cmd_parser_pkg::hex_char(MODEL_NUM[3:0]);
      rlen = 5'd7;
    end else if (cmd_fw) begin
      rbuf[0] = cmd_parser_pkg::CH_BANG; // RULE8
      for (int i = 0; i < cmd_parser_pkg::FW_REV_LEN; i++) begin
        rbuf[3 + i] = cmd_parser_pkg::FW_REV_TEXT[8 * (cmd_parser_pkg::FW_REV_LEN - 1 - i) +: 8];
      end
      rlen = 5'(3 + cmd_parser_pkg::FW_REV_LEN);
    end else if (cmd_rd) begin
      rbuf[0] = cmd_parser_pkg::CH_GT; // RULE15
      for (int i = 0; i < cmd_parser_pkg::FLAG_HEX_CHARS; i++) begin
        rbuf[3 + i] = cmd_parser_pkg::hex_char(4'h0);
      end
      for (int i = 0; i < 4; i++) begin
        rbuf[7 + i] = cmd_parser_pkg::hex_char(flags_r[4 * (3 - i) +: 4]); // RULE13
      end
      rlen = 5'(3 + cmd_parser_pkg::FLAG_HEX_CHARS);
    end else if (cmd_wr) begin
      rbuf[0] = cmd_parser_pkg::CH_GT; // RULE14
    end else begin
      rbuf[0] = cmd_parser_pkg::CH_QM; // RULE5
    end
  end

  assign rsp.start = (state_r == ST_EXEC) && reply;
  assign rsp.len = rlen;
  assign rsp.data = rbuf;

  // Shared flag storage; an accepted command write wins over a same-cycle register write.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= cmd_parser_pkg::FLAG_RESET;
    end else if (state_r == ST_EXEC && reply && cmd_wr) begin
      if (sel_all) begin
        flags_r <= acc[15:0]; // RULE17
      end else begin
        flags_r[flag_num] <= acc[0]; // RULE10
      end
    end else if (reg_wr && reg_addr == cmd_parser_pkg::FLAG_REG_ADDR) begin
      flags_r <= reg_wdata; // RULE11
    end
  end

  // Register read port; unmapped addresses read as zero.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        rdata_r <= (reg_addr == cmd_parser_pkg::FLAG_REG_ADDR) ? flags_r : 16'h0000; // RULE11
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign aux_flags = flags_r;

  resp_sender u_sender (
    .clock(clock),
    .rst_n(rst_n),
    .rsp(rsp),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );

endmodule

// *** hdl/cmd_parser_pkg.sv ***
// Constants, types and character helpers for the ASCII system command parser.
// Assumes one 125 MHz clock and a byte-wide character stream in both directions.
// How it works
// (RULE1) The frame '$', two address characters, 'M' and carriage return is taken as the identity read.
// (RULE2) The address is two hex characters from 00 to FF, and this node answers only to 01.
// (RULE3) Every frame in either direction ends with one carriage return, 0Dh.
// (RULE4) The identity reply is '!', the address, the fixed model prefix, two model number characters and a return.
// (RULE5) A well-formed frame to this node with an unknown operation gets '?', the address and a return.
// (RULE6) Frames with bad syntax, overflow or another address get no reply at all.
// (RULE7) The frame '$', address, 'F' and carriage return is taken as the firmware revision read.
// (RULE8) The revision reply is '!', the address, the revision text and a return.
// (RULE9) A leading '!' or '>' marks an accepted command and a leading '?' a rejected one.
// (RULE10) A '#' frame with address, the flag opcode, a selector and hex data writes one or all flags.
// (RULE11) Sixteen auxiliary flags live in one read/write holding register at address 40305.
// (RULE12) Selector 0000 picks all flags, and '100' followed by one hex character picks flag 0h to Fh.
// (RULE13) Each data hex character carries four consecutive flags, one flag per bit, flag 0 lowest.
// (RULE14) An accepted flag write is answered with '>', the address and a return.
// (RULE15) A flag read is answered with '>', the address, eight hex characters of flags and a return.
// (RULE16) Characters are buffered and decoded only at the return, and a new delimiter drops a partial frame.
// (RULE17) Command writes and register writes share the same sixteen flag bits.
package cmd_parser_pkg;

  // Characters of the protocol.
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_BANG = 8'h21;
  localparam logic [7:0] CH_GT = 8'h3e;
  localparam logic [7:0] CH_QM = 8'h3f;
  localparam logic [7:0] CH_M = 8'h4d;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_V = 8'h56;
  localparam logic [7:0] CH_LD = 8'h64;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_ZERO = 8'h30;

  // Node address, model prefix and revision text.
  localparam logic [7:0] NODE_ADDR = 8'h01;
  localparam logic [15:0] MODEL_PREFIX = 16'h3630;
  localparam int FW_REV_LEN = 9;
  localparam logic [8*FW_REV_LEN-1:0] FW_REV_TEXT = " A0.00B00";

  // Holding register of the flags.
  localparam logic [15:0] FLAG_REG_ADDR = 16'h9d71;
  localparam logic [15:0] FLAG_RESET = 16'h0000;

  // Frame body lengths, counted after the delimiter and before the return.
  localparam int BODY_MAX = 16;
  localparam int LEN_SHORT = 3;
  localparam int LEN_FLAG_RD = 4;
  localparam int LEN_WR_MIN = 12;
  localparam int LEN_WR_MAX = 16;
  localparam int POS_SEL = 4;
  localparam int POS_DATA = 8;
  localparam int FLAG_HEX_CHARS = 8;

  // Reply buffer; the sender appends the return itself.
  localparam int RESP_MAX = 16;
  typedef logic [RESP_MAX-1:0][7:0] resp_buf_t;
  typedef logic [4:0] resp_len_t;

  function automatic logic is_hex(input logic [7:0] c);
    is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    logic [7:0] t;
    t = (c <= 8'h39) ? (c - 8'h30) : (c - 8'h37);
    hex_val = t[3:0];
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

endpackage

// *** hdl/resp_if.sv ***
// Carrier of one reply from the decoder to the character sender.
// Assumes both ends share the parser clock.
`timescale 1ns/1ps
interface resp_if;
  logic start;
  cmd_parser_pkg::resp_len_t len;
  cmd_parser_pkg::resp_buf_t data;
  logic busy;
  modport src (output start, output len, output data, input busy);
  modport snk (input start, input len, input data, output busy);
endinterface

// *** hdl/resp_sender.sv ***
// Character sender: streams a reply buffer out, then a carriage return.
// Assumes the sink may stall tx_ready at any time.
`timescale 1ns/1ps
module resp_sender (
  input wire logic clock,
  input wire logic rst_n,
  resp_if.snk rsp,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready
);

  cmd_parser_pkg::resp_buf_t buf_r;
  cmd_parser_pkg::resp_len_t len_r;
  cmd_parser_pkg::resp_len_t idx_r;
  logic busy_r;
  logic [7:0] data_r;
  cmd_parser_pkg::resp_len_t idx_nxt;

  assign idx_nxt = idx_r + 5'd1;
  assign rsp.busy = busy_r;
  assign tx_valid = busy_r;
  assign tx_data = data_r;

  // Load a reply, then advance on each accepted character; the last one is the return.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      buf_r <= '0;
      len_r <= '0;
      idx_r <= '0;
      busy_r <= 1'b0;
      data_r <= 8'h00;
    end else if (!busy_r) begin
      if (rsp.start) begin
        buf_r <= rsp.data;
        len_r <= rsp.len;
        idx_r <= '0;
        busy_r <= 1'b1;
        data_r <= rsp.data[0];
      end
    end else if (tx_ready) begin
      if (idx_r == len_r) begin
        busy_r <= 1'b0;
      end else begin
        idx_r <= idx_nxt;
        data_r <= (idx_nxt == len_r) ? cmd_parser_pkg::CH_CR : buf_r[idx_nxt[3:0]]; // RULE3
      end
    end
  end

endmodule
